// [core/rtc_page_pkg.sv]
// Constants and types for the paged register space
package rtc_page_pkg;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 5;
    localparam int IDX_W = 3;
    localparam int PAGE_LSB = 3;
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 64;
    localparam int NUM_CNT = 7;
    localparam int CMD_READ_BIT = 7;
    localparam logic [4:0] NUM_PAGES = 5'h08;
    localparam logic [4:0] CLOCK_PAGE = 5'h01;
    localparam logic [4:0] ALARM_PAGE = 5'h02;
    // Registers present in each page 0..7 (RAM pages 0-4,7; EEPROM pages 5,6)
    localparam logic [3:0] PAGE_REGS [8] = '{4'h5, 4'h7, 4'h7, 4'h2, 4'h1, 4'h2, 4'h4, 4'h8};
    // Clock counters: seconds, minutes, hours, days, weekdays, months, years
    localparam logic [7:0] CNT_MIN [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] CNT_MAX [7] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h07, 8'h12, 8'h99};
    // Counter whose carry advances each counter (entry 0 is fed by the tick)
    localparam int CNT_SRC [7] = '{0, 0, 1, 2, 2, 3, 5};
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [3:0] BCD_ONE = 4'h1;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BIT_ONE = 3'h1;
    localparam logic [2:0] IDX_ONE = 3'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } link_state_t;
endpackage : rtc_page_pkg

// [core/bcd_counter.sv]
// Two-digit BCD counter with load and carry
`timescale 1ns/1ns
`default_nettype none
module bcd_counter #(
    parameter logic [7:0] MIN_VAL = 8'h00,
    parameter logic [7:0] MAX_VAL = 8'h59
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic inc_in,
    input wire logic load_in,
    input wire logic [7:0] load_val_in,
    output logic [7:0] val_out,
    output logic carry_out
);
    import rtc_page_pkg::*;

    logic [7:0] val_ff;
    logic [7:0] nxt_val;

    always_comb begin
        nxt_val = val_ff;
        if (load_in) begin
            nxt_val = load_val_in;
        end else if (inc_in) begin
            if (val_ff == MAX_VAL) begin
                nxt_val = MIN_VAL;
            end else if (val_ff[3:0] == BCD_NINE) begin
                nxt_val = {val_ff[7:4] + BCD_ONE, BCD_ZERO}; // RULE8
            end else begin
                nxt_val = {val_ff[7:4], val_ff[3:0] + BCD_ONE}; // RULE8
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            val_ff <= MIN_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign val_out = val_ff;
    assign carry_out = inc_in & (val_ff == MAX_VAL);
endmodule : bcd_counter
`default_nettype wire

// [core/rtc_page_regs.sv]
// Serial-accessed paged register space with frozen clock counters
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE1: Address bits 7..3 select the page.
// RULE2: Address bits 2..0 select the register within the page.
// RULE3: Thirty volatile byte registers spread over six pages.
// RULE4: Six non-volatile byte registers spread over two pages.
// RULE5: Page number stays fixed for the whole access.
// RULE6: Register index advances automatically between consecutive bytes.
// RULE7: Counters freeze while the interface is active.
// RULE8: Clock and alarm time registers hold BCD values.
// RULE9: Other registers hold plain bits or binary values.
// RULE10: Word address advances once after every data byte.
// RULE11: Page one, addresses 08h..0Eh, holds seconds through years.
// RULE12: Page two, addresses 10h..16h, holds alarm match registers.
// RULE13: Index wraps seven to zero without touching the page.
// RULE14: Chip enable low releases counters and applies a pending tick.
module rtc_page_regs
    import rtc_page_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sdi_in,
    input wire logic sec_tick_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic freeze_out
);
    // ****************************************
    // Declarations
    // ****************************************
    link_state_t st_ff, nxt_st;
    logic [2:0] bit_ff, nxt_bit;
    logic [7:0] rx_ff, nxt_rx;
    logic [7:0] tx_ff, nxt_tx;
    logic read_ff, nxt_read;
    logic load_pend_ff, nxt_load_pend;
    logic scl_ff, nxt_scl;
    logic pend_tick_ff, nxt_pend_tick;
    logic [PAGE_W-1:0] page_ff, nxt_page;
    logic [IDX_W-1:0] idx_ff, nxt_idx;
    logic [7:0] mem_ff [MEM_DEPTH];
    logic [7:0] cnt_val [NUM_CNT];
    logic [NUM_CNT-1:0] cnt_inc;
    logic [NUM_CNT-1:0] cnt_carry;
    logic [NUM_CNT-1:0] cnt_load;
    logic [7:0] rx_byte;
    logic [7:0] rd_data;
    logic [MEM_AW-1:0] mem_addr;
    logic scl_rise;
    logic scl_fall;
    logic byte_done;
    logic impl;
    logic wr_en;
    logic tick_go;

    // ****************************************
    // Address decode and read path
    // ****************************************
    assign scl_rise = scl_in & ~scl_ff;
    assign scl_fall = ~scl_in & scl_ff;
    assign rx_byte = {rx_ff[6:0], sdi_in};
    assign byte_done = ce_in & scl_rise & (bit_ff == LAST_BIT);
    assign mem_addr = {page_ff[2:0], idx_ff}; // RULE1 RULE2
    // RULE3 RULE4 RULE11 RULE12
    assign impl = (page_ff < NUM_PAGES) && ({1'b0, idx_ff} < PAGE_REGS[page_ff[2:0]]);
    assign wr_en = byte_done & (st_ff == ST_DATA) & ~read_ff & impl;

    always_comb begin
        rd_data = BYTE_ZERO;
        if (impl) begin
            if (page_ff == CLOCK_PAGE) begin
                rd_data = cnt_val[idx_ff]; // RULE11
            end else begin
                rd_data = mem_ff[mem_addr]; // RULE9
            end
        end
    end

    // ****************************************
    // Clock counters
    // ****************************************
    // One tick during an access waits until chip enable drops; further ticks in that access are merged into it
    assign tick_go = (sec_tick_in | pend_tick_ff) & ~ce_in; // RULE7 RULE14
    assign nxt_pend_tick = ce_in & (pend_tick_ff | sec_tick_in); // RULE14
    assign freeze_out = ce_in; // RULE7

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        if (i == 0) begin : g_first
            assign cnt_inc[i] = tick_go;
        end else begin : g_next
            assign cnt_inc[i] = cnt_carry[CNT_SRC[i]];
        end
        assign cnt_load[i] = wr_en & (page_ff == CLOCK_PAGE) & (idx_ff == IDX_W'(i)); // RULE11
        bcd_counter #(
            .MIN_VAL(CNT_MIN[i]),
            .MAX_VAL(CNT_MAX[i])
        ) u_cnt (
            .clk_in(clk_in),
            .sys_rst_in(sys_rst_in),
            .inc_in(cnt_inc[i]),
            .load_in(cnt_load[i]),
            .load_val_in(rx_byte),
            .val_out(cnt_val[i]),
            .carry_out(cnt_carry[i])
        ); // RULE8
    end

    // ****************************************
    // Register storage
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int k = 0; k < MEM_DEPTH; k++) begin
                mem_ff[k] <= BYTE_ZERO;
            end
        end else if (wr_en && (page_ff != CLOCK_PAGE)) begin
            mem_ff[mem_addr] <= rx_byte; // RULE3 RULE4 RULE9 RULE12
        end
    end

    // ****************************************
    // Serial access sequencer
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_read = read_ff;
        nxt_load_pend = load_pend_ff;
        nxt_page = page_ff;
        nxt_idx = idx_ff;
        nxt_scl = scl_in;
        if (!ce_in) begin
            nxt_st = ST_CMD;
            nxt_bit = 3'h0;
            nxt_read = 1'b0;
            nxt_load_pend = 1'b0;
        end else begin
            if (scl_rise) begin
                nxt_rx = rx_byte;
                nxt_bit = bit_ff + BIT_ONE;
                if (bit_ff == LAST_BIT) begin
                    unique case (st_ff)
                        ST_CMD: begin
                            nxt_read = rx_byte[CMD_READ_BIT];
                            nxt_st = ST_ADDR;
                        end
                        ST_ADDR: begin
                            nxt_page = rx_byte[7:PAGE_LSB]; // RULE1
                            nxt_idx = rx_byte[PAGE_LSB-1:0]; // RULE2
                            nxt_load_pend = read_ff;
                            nxt_st = ST_DATA;
                        end
                        ST_DATA: begin
                            // Page untouched here, index wraps at seven
                            nxt_idx = idx_ff + IDX_ONE; // RULE5 RULE6 RULE10 RULE13
                            nxt_load_pend = read_ff;
                        end
                        default: begin
                            nxt_st = ST_CMD;
                        end
                    endcase
                end
            end
            if (scl_fall) begin
                if (load_pend_ff) begin
                    nxt_tx = rd_data;
                    nxt_load_pend = 1'b0;
                end else begin
                    nxt_tx = {tx_ff[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_ff <= ST_CMD;
            bit_ff <= 3'h0;
            rx_ff <= BYTE_ZERO;
            tx_ff <= BYTE_ZERO;
            read_ff <= 1'b0;
            load_pend_ff <= 1'b0;
            page_ff <= 5'h00;
            idx_ff <= 3'h0;
            scl_ff <= 1'b0;
            pend_tick_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            read_ff <= nxt_read;
            load_pend_ff <= nxt_load_pend;
            page_ff <= nxt_page;
            idx_ff <= nxt_idx;
            scl_ff <= nxt_scl;
            pend_tick_ff <= nxt_pend_tick;
        end
    end

    assign sdo_out = tx_ff[7];
    assign sdo_oe_out = ce_in & read_ff & (st_ff == ST_DATA);
endmodule : rtc_page_regs
`default_nettype wire

// [verification/rtc_page_checker.sv]
// Port checks for the paged register block
`timescale 1ns/1ns
`default_nettype none
module rtc_page_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sdi_in,
    input wire logic sec_tick_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic freeze_out
);
    logic scl_q_ff;
    logic fall_w;
    logic [4:0] rise_ff;
    logic [4:0] nxt_rise;
    assign fall_w = !scl_in && scl_q_ff;
    always_comb begin
        nxt_rise = ce_in ? rise_ff : 5'h00;
        if (ce_in && scl_in && !scl_q_ff && rise_ff != 5'h1f) begin
            nxt_rise = rise_ff + 5'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        scl_q_ff <= scl_in;
        rise_ff <= sys_rst_in ? 5'h00 : nxt_rise;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_freeze_is_ce: assert property (freeze_out == ce_in) else $error("freeze");
    a_oe_needs_ce: assert property (sdo_oe_out |-> ce_in) else $error("oe");
    a_oe_after_addr: assert property (sdo_oe_out |-> rise_ff >= 5'h10) else $error("oe early");
    a_oe_holds: assert property (sdo_oe_out && ce_in |=> sdo_oe_out || !ce_in) else $error("oe");
    a_sdo_on_fall: assert property ($changed(sdo_out) && $past(ce_in) |-> $past(fall_w))
        else $error("sdo moved");
    a_sdo_still_high: assert property (scl_in && scl_q_ff && ce_in |=> $stable(sdo_out))
        else $error("sdo moved");
    a_oe_reset_low: assert property (disable iff (1'b0) sys_rst_in |=> !sdo_oe_out)
        else $error("oe reset");
    a_abort_clears: assert property ($fell(ce_in) ##1 ce_in |-> !sdo_oe_out)
        else $error("abort");
endmodule : rtc_page_checker
`default_nettype wire

// [verification/spi_host_model.sv]
// Serial host model driving chip enable, clock and data
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic ce_out,
    output logic scl_out,
    output logic sdi_out
);
    initial begin
        ce_out = 1'b0;
        scl_out = 1'b0;
        sdi_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_clk
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi_out = tx[i];
            wait_clk(2);
            scl_out = 1'b1;
            rx[i] = sdo_in;
            wait_clk(2);
            scl_out = 1'b0;
        end
    endtask : xbyte
    task automatic begin_access(input logic [7:0] cmd, input logic [7:0] addr);
        logic [7:0] d;
        ce_out = 1'b1;
        wait_clk(1);
        xbyte(cmd, d);
        xbyte(addr, d);
    endtask : begin_access
    task automatic end_access(input int gap);
        wait_clk(2);
        ce_out = 1'b0;
        sdi_out = ~sdi_out;
        wait_clk(gap);
    endtask : end_access
endmodule : spi_host_model
`default_nettype wire

// [verification/rtc_page_regs_tb_top.sv]
// Testbench for the paged register block
`timescale 1ns/1ns
`default_nettype none
module rtc_page_regs_tb_top;
    import rtc_page_pkg::*;
    localparam logic [15:0] MAP [4] = '{16'h4000, 16'h0f00, 16'h2100, 16'h295a};
    logic clk_in;
    logic sys_rst_in;
    logic sec_tick_in;
    wire logic ce, scl, sdi;
    logic sdo, sdo_oe, frz;
    logic [7:0] d;
    logic [7:0] got [8];
    int miscompares = 0;
    int comparisons = 0;
    always #50 clk_in = ~clk_in;
    rtc_page_regs rtc_page_regs_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
        .scl_in(scl), .sdi_in(sdi), .sec_tick_in(sec_tick_in), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .freeze_out(frz));
    spi_host_model spi_host_model_inst (.clk_in(clk_in), .sdo_in(sdo), .ce_out(ce),
        .scl_out(scl), .sdi_out(sdi));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask : check
    task automatic wr(input logic [7:0] addr, input logic [7:0] first, input int n);
        spi_host_model_inst.begin_access(8'h00, addr);
        for (int i = 0; i < n; i++) spi_host_model_inst.xbyte(first + 8'(i), d);
        spi_host_model_inst.end_access(2);
    endtask : wr
    task automatic rd(input logic [7:0] addr, input int n);
        spi_host_model_inst.begin_access(8'h80, addr);
        for (int i = 0; i < n; i++) spi_host_model_inst.xbyte(8'h00, got[i]);
        spi_host_model_inst.end_access(2);
    endtask : rd
    task automatic pulse;
        sec_tick_in = 1'b1;
        spi_host_model_inst.wait_clk(1);
        sec_tick_in = 1'b0;
        spi_host_model_inst.wait_clk(1);
    endtask : pulse
    task automatic s_wrap;
        wr(8'h3e, 8'ha0, 8);
        rd(8'h38, 8);
        for (int i = 0; i < 8; i++) check("wrap", got[i], 8'ha0 + 8'((i + 2) % 8));
        rd(8'h3f, 2);
        check("page", got[1], 8'ha2);
    endtask : s_wrap
    task automatic s_map;
        for (int i = 0; i < 4; i++) begin
            wr(MAP[i][15:8], 8'h5a, 1);
            rd(MAP[i][15:8], 1);
            check("map", got[0], MAP[i][7:0]);
        end
    endtask : s_map
    task automatic s_freeze;
        spi_host_model_inst.begin_access(8'h00, 8'h08);
        spi_host_model_inst.xbyte(8'h59, d);
        spi_host_model_inst.xbyte(8'h59, d);
        spi_host_model_inst.xbyte(8'h23, d);
        pulse();
        pulse();
        check("freeze", {7'h00, frz}, 8'h01);
        spi_host_model_inst.end_access(1);
        rd(8'h08, 4);
        for (int i = 0; i < 4; i++) check("clock", got[i], i == 3 ? 8'h02 : 8'h00);
        wr(8'h08, 8'h09, 1);
        pulse();
        rd(8'h08, 1);
        check("bcd", got[0], 8'h10);
    endtask : s_freeze
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        clk_in = 1'b0;
        sys_rst_in = 1'b1;
        sec_tick_in = 1'b0;
        spi_host_model_inst.wait_clk(8);
        sys_rst_in = 1'b0;
        spi_host_model_inst.wait_clk(2);
        s_wrap();
        s_map();
        s_freeze();
        final_report();
    end
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
endmodule : rtc_page_regs_tb_top
bind rtc_page_regs rtc_page_checker rtc_page_checker_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .ce_in(ce_in), .scl_in(scl_in), .sdi_in(sdi_in),
    .sec_tick_in(sec_tick_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .freeze_out(freeze_out));
`default_nettype wire
